// [rtl/msr_consts.vh]
// constants for the service sequencer: offsets, fields, resets, counts
`ifndef MSR_CONSTS_VH
`define MSR_CONSTS_VH

// register byte offsets
`define MSR_OFF_CTRL    8'h00
`define MSR_OFF_COUNT   8'h04
`define MSR_OFF_RING    8'h08
`define MSR_OFF_PTR     8'h0C
`define MSR_OFF_STAT    8'h10
`define MSR_OFF_TABLE   8'h14
`define MSR_OFF_CWORD   8'h18

// control fields
`define MSR_CTRL_SMB    0
`define MSR_CTRL_VCE    1
`define MSR_CTRL_RING   2
`define MSR_CTRL_CNTM   3
`define MSR_CTRL_DEC    4
`define MSR_CTRL_TPU    5
`define MSR_CTRL_MASK   6
`define MSR_CTRL_W      7

// status fields
`define MSR_ST_REQ      0
`define MSR_ST_HOLD     1
`define MSR_ST_SUSP     2
`define MSR_ST_BUSY     3

// reset values
`define MSR_RST_CTRL    7'h00
`define MSR_RST_COUNT   16'h0000
`define MSR_RST_BYTE    8'h00

// timing counts in clock cycles
`define MSR_HOLD_CYC    4'h8
`define MSR_RESOLVE_CYC 4'h8

// sizes
`define MSR_PAT_W       8
`define MSR_TABLE_AW    4
`define MSR_FIFO_DEPTH  8
`define MSR_FIFO_AW     3

`endif

// [rtl/msr_fifo.v]
// synchronous fifo with valid and ready on both sides
module msr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clock,
  input  wire             rstn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;

  wire full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push  = in_valid && !full;
  wire pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // msr_fifo

// [rtl/msr_hold_timer.v]
// down counter that stays busy for a loaded number of cycles
module msr_hold_timer #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clock,
  input  wire         rstn,
  // control
  input  wire         load,
  input  wire [W-1:0] value,
  // state
  output wire         busy
);

  reg [W-1:0] cnt;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt <= {W{1'b0}};
    end else if (load) begin
      cnt <= value;
    end else if (cnt != {W{1'b0}}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt != {W{1'b0}});

endmodule // msr_hold_timer

// [rtl/msr_top.v]
// request sequencer with ring pattern service, counter mode and ack hold
//
// How it works
// - ring mode steps the one-cycle pattern table in order and wraps until the transfer count reaches zero
// - every performed transfer outside counter mode decrements the transfer count by one
// - count reaching zero with the vectored-on-end enable set raises the end request too
// - counter mode moves no data, only decrements the channel count word per request
// - counter mode channel is one 16-bit word in internal ram
// - channel pointer gives the low 8 address bits of that word
// - a deferring instruction holds ack and service for 8 clocks
// - software traps are acknowledged at once, never held
// - the sequencer flags which instructions belong to the deferring class
// - a self-looping deferring branch keeps restarting the hold
// - block instructions are suspended by a request and resumed afterwards
// - a set request flag takes 8 clocks of priority resolution
// - resolved enabled requests are acknowledged at instruction end
// - after a deferring instruction, ack waits for the next one's end
// - ring step counts down, at one pointer rewinds and step reloads
// - count zero clears service mode, then vectors or clears the flag
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`include "msr_consts.vh"

module msr_top (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // peripheral request source
  input  wire        hw_req,
  // instruction sequencer
  input  wire        instr_end,
  input  wire        instr_defer,
  input  wire        instr_block,
  input  wire        service_done,
  input  wire        sw_trap,
  // acknowledge outputs
  output reg         int_ack,
  output wire        sw_trap_ack,
  output reg         block_suspend,
  output reg         block_resume,
  // pattern output stream
  output wire        pat_valid,
  input  wire        pat_ready,
  output wire [7:0]  pat_data
);

  localparam [4:0] ST_IDLE    = 5'b00001;
  localparam [4:0] ST_RESOLVE = 5'b00010;
  localparam [4:0] ST_WAIT    = 5'b00100;
  localparam [4:0] ST_XFER    = 5'b01000;
  localparam [4:0] ST_VECT    = 5'b10000;

  // software state
  reg [`MSR_CTRL_W-1:0] ctrl;
  reg [15:0]            transfer_count;
  reg [7:0]             pattern_length;
  reg [7:0]             pattern_step_count;
  reg [7:0]             pattern_data_pointer;
  reg [7:0]             timing_data_pointer;
  reg [7:0]             channel_pointer;
  reg [7:0]             pattern_table [0:(1<<`MSR_TABLE_AW)-1];
  reg [15:0]            count_ram [0:255];

  // sequencing state
  reg [4:0]             state;
  reg [4:0]             next_state;
  reg                   req_flag;
  reg                   suspended;

  // bus state
  reg                   wr_pend;
  reg [7:0]             wr_addr;

  wire service_mode_bit       = ctrl[`MSR_CTRL_SMB];
  wire vectored_on_end_enable = ctrl[`MSR_CTRL_VCE];
  wire ring_on                = ctrl[`MSR_CTRL_RING];
  wire counter_mode           = ctrl[`MSR_CTRL_CNTM];
  wire dir_down               = ctrl[`MSR_CTRL_DEC];
  wire timing_update          = ctrl[`MSR_CTRL_TPU];
  wire req_masked             = ctrl[`MSR_CTRL_MASK];

  // hold and resolution timers
  wire hold_load = instr_end && instr_defer;
  wire hold_busy;
  wire res_load  = (state == ST_IDLE) && req_flag;
  wire res_busy;

  msr_hold_timer #(.W(4)) u_hold (
    .clock (clock),
    .rstn  (rstn),
    .load  (hold_load),
    .value (`MSR_HOLD_CYC),
    .busy  (hold_busy)
  );

  msr_hold_timer #(.W(4)) u_resolve (
    .clock (clock),
    .rstn  (rstn),
    .load  (res_load),
    .value (`MSR_RESOLVE_CYC),
    .busy  (res_busy)
  );

  // acknowledge point
  wire at_end   = instr_end && !instr_defer;
  wire ack_ok   = (state == ST_WAIT) && !hold_busy && !req_masked;
  wire ack_end  = ack_ok && at_end;
  wire ack_blk  = ack_ok && !instr_end && instr_block;
  wire ack_now  = ack_end || ack_blk;

  assign sw_trap_ack = sw_trap;

  // transfer step
  wire [7:0]  pat_word   = pattern_table[pattern_data_pointer[`MSR_TABLE_AW-1:0]];
  wire [15:0] cword      = count_ram[channel_pointer];
  wire        fifo_ready;
  wire        do_xfer    = (state == ST_XFER) && (counter_mode || fifo_ready);
  wire        push       = (state == ST_XFER) && !counter_mode;
  wire [15:0] cnt_next   = transfer_count - 16'h0001;
  wire [15:0] cword_next = cword - 16'h0001;
  wire        end_reach  = counter_mode ? (cword_next == 16'h0000)
                                        : (cnt_next == 16'h0000);
  wire [7:0]  ptr_step   = dir_down ? (pattern_data_pointer - 8'h01)
                                    : (pattern_data_pointer + 8'h01);
  wire        ring_wrap  = (pattern_step_count == 8'h01);
  wire [7:0]  ptr_wrap   = dir_down ? (ptr_step + pattern_length)
                                    : (ptr_step - pattern_length);

  msr_fifo #(
    .WIDTH (`MSR_PAT_W),
    .DEPTH (`MSR_FIFO_DEPTH),
    .AW    (`MSR_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (pat_word),
    .out_valid (pat_valid),
    .out_ready (pat_ready),
    .out_data  (pat_data)
  );

  // state sequence
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_flag) begin
          next_state = ST_RESOLVE;
        end
      end
      ST_RESOLVE: begin
        if (!res_busy) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ack_now) begin
          next_state = service_mode_bit ? ST_XFER : ST_VECT;
        end
      end
      ST_XFER: begin
        if (do_xfer) begin
          next_state = ST_IDLE;
        end
      end
      ST_VECT: begin
        if (service_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // request flag, set wins over every clear
  wire sw_flag_clr = wr_pend && (wr_addr == `MSR_OFF_STAT) && hwdata[`MSR_ST_REQ];
  wire vec_clr     = ack_now && !service_mode_bit;
  wire end_clr     = do_xfer && !(end_reach && vectored_on_end_enable);
  wire flag_clr    = sw_flag_clr || vec_clr || end_clr;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state         <= ST_IDLE;
      req_flag      <= 1'b0;
      suspended     <= 1'b0;
      int_ack       <= 1'b0;
      block_suspend <= 1'b0;
      block_resume  <= 1'b0;
    end else begin
      state         <= next_state;
      int_ack       <= vec_clr;
      block_suspend <= ack_blk;
      block_resume  <= 1'b0;
      if (hw_req) begin
        req_flag <= 1'b1;
      end else if (flag_clr) begin
        req_flag <= 1'b0;
      end
      if (ack_blk) begin
        suspended <= 1'b1;
      end else if (suspended && (next_state == ST_IDLE) && (state != ST_IDLE)) begin
        suspended    <= 1'b0;
        block_resume <= 1'b1;
      end
    end
  end

  // register file and channel updates
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl                 <= `MSR_RST_CTRL;
      transfer_count       <= `MSR_RST_COUNT;
      pattern_length       <= `MSR_RST_BYTE;
      pattern_step_count   <= `MSR_RST_BYTE;
      pattern_data_pointer <= `MSR_RST_BYTE;
      timing_data_pointer  <= `MSR_RST_BYTE;
      channel_pointer      <= `MSR_RST_BYTE;
    end else begin
      if (wr_pend) begin
        case (wr_addr)
          `MSR_OFF_CTRL: begin
            ctrl <= hwdata[`MSR_CTRL_W-1:0];
          end
          `MSR_OFF_COUNT: begin
            transfer_count <= hwdata[15:0];
          end
          `MSR_OFF_RING: begin
            pattern_length     <= hwdata[7:0];
            pattern_step_count <= hwdata[15:8];
          end
          `MSR_OFF_PTR: begin
            pattern_data_pointer <= hwdata[7:0];
            timing_data_pointer  <= hwdata[15:8];
            channel_pointer      <= hwdata[23:16];
          end
          default: begin
          end
        endcase
      end
      if (do_xfer) begin
        if (end_reach) begin
          ctrl[`MSR_CTRL_SMB] <= 1'b0;
        end
        if (!counter_mode) begin
          transfer_count <= cnt_next;
          if (timing_update) begin
            timing_data_pointer <= dir_down ? (timing_data_pointer - 8'h01)
                                            : (timing_data_pointer + 8'h01);
          end
          if (!ring_on) begin
            pattern_data_pointer <= ptr_step;
          end else if (ring_wrap) begin
            pattern_data_pointer <= ptr_wrap;
            pattern_step_count   <= pattern_length;
          end else begin
            pattern_data_pointer <= ptr_step;
            pattern_step_count   <= pattern_step_count - 8'h01;
          end
        end
      end
    end
  end

  // pattern table and count words
  always @(posedge clock) begin
    if (wr_pend && (wr_addr == `MSR_OFF_TABLE)) begin
      pattern_table[hwdata[8+`MSR_TABLE_AW-1:8]] <= hwdata[7:0];
    end
    if (do_xfer && counter_mode) begin
      count_ram[channel_pointer] <= cword_next;
    end else if (wr_pend && (wr_addr == `MSR_OFF_CWORD)) begin
      count_ram[channel_pointer] <= hwdata[15:0];
    end
  end

  // bus slave
  wire access = hsel && htrans[1] && hready;
  reg [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `MSR_OFF_CTRL: begin
        rd_mux[`MSR_CTRL_W-1:0] = ctrl;
      end
      `MSR_OFF_COUNT: begin
        rd_mux[15:0] = transfer_count;
      end
      `MSR_OFF_RING: begin
        rd_mux[15:0] = {pattern_step_count, pattern_length};
      end
      `MSR_OFF_PTR: begin
        rd_mux[23:0] = {channel_pointer, timing_data_pointer, pattern_data_pointer};
      end
      `MSR_OFF_STAT: begin
        rd_mux[`MSR_ST_REQ]  = req_flag;
        rd_mux[`MSR_ST_HOLD] = hold_busy;
        rd_mux[`MSR_ST_SUSP] = suspended;
        rd_mux[`MSR_ST_BUSY] = (state != ST_IDLE);
      end
      `MSR_OFF_CWORD: begin
        rd_mux[15:0] = cword;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      wr_pend <= access && hwrite;
      wr_addr <= haddr[7:0];
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule // msr_top

// [verification/msr_seq_model.sv]
// instruction sequencer and pattern sink model
module msr_seq_model (
  // clock and reset
  input  wire  clock,
  input  wire  rstn,
  // bench controls
  input  wire  defer_on,
  input  wire  blk_on,
  input  wire  stall,
  // from sequencer block
  input  wire  int_ack,
  // to sequencer block
  output logic instr_end,
  output logic instr_defer,
  output logic instr_block,
  output logic service_done,
  output logic pat_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;
  logic [2:0] sd;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      sd <= 3'h0;
      instr_end <= 1'b0;
      instr_defer <= 1'b0;
      instr_block <= 1'b0;
      service_done <= 1'b0;
      pat_ready <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      instr_end <= ph == 2'h3 && !blk_on;
      instr_defer <= defer_on;
      instr_block <= blk_on;
      pat_ready <= !stall;
      sd <= int_ack ? 3'h4 : (sd != 3'h0 ? sd - 3'h1 : 3'h0);
      service_done <= sd == 3'h1;
    end
  end
endmodule // msr_seq_model

// [verification/msr_top_monitor.sv]
// port assertions for the service sequencer
module msr_top_monitor (
  // clock and reset
  input wire       clock,
  input wire       rstn,
  // bus answer
  input wire       hreadyout,
  input wire       hresp,
  // sequencer side
  input wire       instr_end,
  input wire       instr_defer,
  input wire       instr_block,
  input wire       sw_trap,
  // acknowledges
  input wire       sw_trap_ack,
  input wire       int_ack,
  input wire       block_suspend,
  input wire       block_resume,
  // pattern stream
  input wire       pat_valid,
  input wire       pat_ready,
  input wire [7:0] pat_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_trap_at_once: assert property (
    sw_trap_ack == sw_trap) else $error("trap ack wrong");
  a_defer_hold: assert property (
    instr_end && instr_defer |=> (!(int_ack || block_suspend)) [*8])
    else $error("ack inside hold");
  a_ack_cause: assert property (
    int_ack |-> $past(instr_end && !instr_defer || instr_block && !instr_end))
    else $error("ack without cause");
  a_suspend_cause: assert property (
    block_suspend |-> $past(instr_block && !instr_end))
    else $error("suspend without block");
  a_ack_pulse: assert property (
    int_ack |=> !int_ack) else $error("ack too long");
  a_resume_pulse: assert property (
    block_resume |=> !block_resume) else $error("resume too long");
  a_pattern_stable: assert property (
    pat_valid && !pat_ready |=> pat_valid && $stable(pat_data))
    else $error("pattern dropped");
  a_bus_okay: assert property (
    hreadyout && !hresp) else $error("bus answer wrong");
endmodule // msr_top_monitor

bind msr_top msr_top_monitor mon (.clock(clock), .rstn(rstn),
  .hreadyout(hreadyout), .hresp(hresp), .instr_end(instr_end),
  .instr_defer(instr_defer), .instr_block(instr_block), .sw_trap(sw_trap),
  .sw_trap_ack(sw_trap_ack), .int_ack(int_ack), .block_suspend(block_suspend),
  .block_resume(block_resume), .pat_valid(pat_valid), .pat_ready(pat_ready),
  .pat_data(pat_data));

// [verification/msr_top_tb.sv]
// self-checking bench for the service sequencer
`include "msr_consts.vh"
module msr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hw_req = 1'b0;
  logic        sw_trap = 1'b0;
  logic        defer_on = 1'b0;
  logic        blk_on = 1'b0;
  logic        stall = 1'b0;
  wire         hreadyout, hresp, sw_trap_ack, pat_valid, pat_ready, int_ack;
  wire         instr_end, instr_defer, instr_block, service_done;
  wire         block_suspend, block_resume;
  wire [31:0]  hrdata;
  wire [7:0]   pat_data;
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_ack = 0;
  int          n_sus = 0;
  int          n_res = 0;
  int          k, t;
  logic [7:0]  got_q[$];
  logic [31:0] rd;
  always #5 clock = ~clock;
  msr_top dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hw_req(hw_req), .instr_end(instr_end), .instr_defer(instr_defer),
    .instr_block(instr_block), .service_done(service_done), .sw_trap(sw_trap),
    .int_ack(int_ack), .sw_trap_ack(sw_trap_ack), .block_suspend(block_suspend),
    .block_resume(block_resume), .pat_valid(pat_valid), .pat_ready(pat_ready),
    .pat_data(pat_data));
  msr_seq_model model (.clock(clock), .rstn(rstn), .defer_on(defer_on),
    .blk_on(blk_on), .stall(stall), .int_ack(int_ack), .instr_end(instr_end),
    .instr_defer(instr_defer), .instr_block(instr_block),
    .service_done(service_done), .pat_ready(pat_ready));
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    n_ack <= n_ack + (int_ack === 1'b1);
    n_sus <= n_sus + (block_suspend === 1'b1);
    n_res <= n_res + (block_resume === 1'b1);
    if (pat_valid === 1'b1 && pat_ready === 1'b1) got_q.push_back(pat_data);
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task req(input int n);
    hw_req <= 1'b1;
    @(posedge clock);
    hw_req <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task await_ack(input int lim);
    k = n_ack;
    t = cyc;
    while (n_ack == k && cyc - t < lim) @(posedge clock);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rdc(`MSR_OFF_CTRL, 32'h0);
    rdc(`MSR_OFF_STAT, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdc(8'h1C, 32'h0);
    req(0);
    await_ack(40);
    chk(cyc - t >= 9 && cyc - t <= 24, 1);
    repeat (10) @(posedge clock);
    rdc(`MSR_OFF_STAT, 32'h0);
    defer_on <= 1'b1;
    req(0);
    await_ack(60);
    chk(n_ack - k, 0);
    sw_trap <= 1'b1;
    @(negedge clock);
    chk(sw_trap_ack, 1'b1);
    @(posedge clock);
    sw_trap <= 1'b0;
    bus(1'b0, `MSR_OFF_STAT, 32'h0);
    chk(rd[0], 1'b1);
    chk(rd[1], 1'b1);
    defer_on <= 1'b0;
    await_ack(40);
    chk(n_ack - k, 1);
    repeat (10) @(posedge clock);
    wr(`MSR_OFF_CTRL, 32'h40);
    req(0);
    await_ack(40);
    chk(n_ack - k, 0);
    wr(`MSR_OFF_CTRL, 32'h0);
    await_ack(40);
    chk(n_ack - k, 1);
    repeat (10) @(posedge clock);
    for (int i = 0; i < 4; i++) wr(`MSR_OFF_TABLE, (i << 8) + 8'hA0 + i);
    wr(`MSR_OFF_RING, 32'h0404);
    wr(`MSR_OFF_PTR, 32'h0);
    wr(`MSR_OFF_COUNT, 32'hA);
    stall <= 1'b1;
    wr(`MSR_OFF_CTRL, 32'h07);
    repeat (9) req(24);
    chk(pat_valid, 1'b1);
    rdc(`MSR_OFF_COUNT, 32'h2);
    stall <= 1'b0;
    repeat (30) @(posedge clock);
    rdc(`MSR_OFF_COUNT, 32'h1);
    req(0);
    await_ack(60);
    chk(n_ack - k, 1);
    rdc(`MSR_OFF_COUNT, 32'h0);
    rdc(`MSR_OFF_CTRL, 32'h06);
    chk(got_q.size(), 10);
    foreach (got_q[i]) chk(got_q[i], 8'hA0 + i % 4);
    wr(`MSR_OFF_PTR, 32'h5A0000);
    wr(`MSR_OFF_CWORD, 32'hFFFF_FFFF);
    rdc(`MSR_OFF_CWORD, 32'hFFFF);
    wr(`MSR_OFF_PTR, 32'h5B0000);
    wr(`MSR_OFF_CWORD, 32'h2);
    wr(`MSR_OFF_PTR, 32'h5A0000);
    rdc(`MSR_OFF_CWORD, 32'hFFFF);
    wr(`MSR_OFF_PTR, 32'h5B0000);
    wr(`MSR_OFF_COUNT, 32'h55);
    wr(`MSR_OFF_CTRL, 32'h09);
    repeat (2) req(24);
    rdc(`MSR_OFF_CWORD, 32'h0);
    rdc(`MSR_OFF_COUNT, 32'h55);
    rdc(`MSR_OFF_CTRL, 32'h08);
    chk(got_q.size(), 10);
    wr(`MSR_OFF_COUNT, 32'h5);
    wr(`MSR_OFF_CTRL, 32'h01);
    blk_on <= 1'b1;
    req(30);
    blk_on <= 1'b0;
    chk(n_sus, 1);
    chk(n_res, 1);
    rdc(`MSR_OFF_COUNT, 32'h4);
    wr(`MSR_OFF_PTR, 32'h3);
    wr(`MSR_OFF_RING, 32'h0404);
    wr(`MSR_OFF_COUNT, 32'h5);
    wr(`MSR_OFF_CTRL, 32'h35);
    repeat (5) req(24);
    repeat (4) @(posedge clock);
    rdc(`MSR_OFF_PTR, 32'hFB02);
    rdc(`MSR_OFF_CTRL, 32'h34);
    chk(got_q.size(), 16);
    chk(got_q[10], 8'hA0);
    for (int i = 11; i < 16; i++) chk(got_q[i], 8'hA3 - (i + 1) % 4);
    give_verdict();
  end
endmodule // msr_top_tb
